// ---- led_fault_blink.sv ----
// Operation
// - each fault shown as six data bits then an end part
// - a zero bit is a 50 ms on phase
// - a one bit is a 500 ms on phase
// - each bit is followed by a 1000 ms off pause
// - after six bits, 2000 ms on then 2000 ms off
// - frames repeat whole; fault changes only at a frame boundary
// - with several faults only one code is shown
// - legacy mode flashes on overtemperature only
// - numbers: test processor 1, converter 2, overtemperature 3
// - measurement processor 4, function 5, insulation 6, earth 7
// - safety 8, front panel 9, second user interface 10, add-on 11
// - electronic source 12, transformer 13, source 14, matrix 15
// - overtemperature above 70 C, cleared below 55 C
// - overload converter fault clears within 10 s
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "led_fault_defs.svh"

module led_fault_blink
#(
    parameter logic [31:0] SHORT_ON_CYC  = 32'(`SHORT_ON_MS * `CLK_KHZ),
    parameter logic [31:0] MEDIUM_ON_CYC = 32'(`MEDIUM_ON_MS * `CLK_KHZ),
    parameter logic [31:0] PAUSE_CYC     = 32'(`PAUSE_OFF_MS * `CLK_KHZ),
    parameter logic [31:0] END_ON_CYC    = 32'(`END_ON_MS * `CLK_KHZ),
    parameter logic [31:0] END_OFF_CYC   = 32'(`END_OFF_MS * `CLK_KHZ),
    parameter logic [31:0] LEGACY_CYC    = 32'(`LEGACY_HALF_MS * `CLK_KHZ),
    parameter logic [31:0] HOLD_CYC = 32'(`OVERLOAD_HOLD_MS * `CLK_KHZ)
)
(
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire led_fault_pkg::fault_in_s faults,
    input  wire logic [7:0]               temp_c,
    input  wire led_fault_pkg::reg_req_s  reg_req,
    output logic [`REG_DW-1:0]            reg_rdata,
    output logic                          led,
    output logic                          irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    led_fault_pkg::phase_e state_r;
    led_fault_pkg::phase_e state_nxt;
    logic [31:0]           cnt_r;
    logic [2:0]            bit_idx_r;
    logic [2:0]            bit_idx_nxt;
    logic [`CODE_W-1:0]    code_r;
    logic [`CODE_W-1:0]    code_nxt;
    logic                  flash_r;
    logic                  flash_nxt;
    logic                  led_r;
    logic                  done;
    logic                  restart;
    logic                  overtemp;
    logic                  converter_fault;
    logic [15:0]           fault_vec;
    logic                  fault_any_r;
    logic                  legacy_r;
    logic [`EV_W-1:0]      status_r;
    logic [`EV_W-1:0]      mask_r;
    logic [`EV_W-1:0]      events;
    logic [`REG_DW-1:0]    rdata_r;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] phase_len(
        input led_fault_pkg::phase_e ph,
        input logic                  bitv
    );
        logic [31:0] len;
        len = 32'h0000_0001;
        case (ph)
            led_fault_pkg::PH_BIT_ON:  len = bitv ? MEDIUM_ON_CYC
                                                  : SHORT_ON_CYC;
            led_fault_pkg::PH_BIT_OFF: len = PAUSE_CYC;
            led_fault_pkg::PH_END_ON:  len = END_ON_CYC;
            led_fault_pkg::PH_END_OFF: len = END_OFF_CYC;
            led_fault_pkg::PH_LEGACY:  len = LEGACY_CYC;
            default:                   len = 32'h0000_0001;
        endcase
        return len;
    endfunction : phase_len

    // scans down so the last hit is the lowest number
    function automatic logic [`CODE_W-1:0] lowest_fault(
        input logic [15:0] v
    );
        logic [`CODE_W-1:0] num;
        num = '0;
        for (int i = 15; i >= 1; i--)
        begin
            if (v[i])
                num = `CODE_W'(i);
        end
        return num;
    endfunction : lowest_fault

    // ----------------------------------------------------------------
    // fault sources
    // ----------------------------------------------------------------
    temp_hysteresis u_temp
    (
        .clk     (clk),
        .reset_n (reset_n),
        .temp_c  (temp_c),
        .over_r  (overtemp)
    );

    overload_hold #(.HOLD_CYC(HOLD_CYC)) u_hold
    (
        .clk            (clk),
        .reset_n        (reset_n),
        .converter_fail (faults.converter_fail),
        .overload       (faults.overload),
        .fault_r        (converter_fault)
    );

    always_comb
    begin
        fault_vec = 16'h0000;
        fault_vec[1]                = faults.test_processor_link;
        fault_vec[`FAULT_CONVERTER] = converter_fault;
        fault_vec[`FAULT_OVERTEMP]  = overtemp;
        fault_vec[4]  = faults.measurement_processor_link;
        fault_vec[5]  = faults.measurement_function_link;
        fault_vec[6]  = faults.insulation_test_link;
        fault_vec[7]  = faults.earth_test_link;
        fault_vec[8]  = faults.safety_link;
        fault_vec[9]  = faults.front_panel_link;
        fault_vec[10] = faults.user_if2_link;
        fault_vec[11] = faults.addon_module_link;
        fault_vec[12] = faults.ext_electronic_link;
        fault_vec[13] = faults.transformer_link;
        fault_vec[14] = faults.ext_source_link;
        fault_vec[15] = faults.matrix_link;
    end

    // ----------------------------------------------------------------
    // phase sequencer
    // ----------------------------------------------------------------
    assign done = (cnt_r == 32'h0000_0000);

    always_comb
    begin
        state_nxt   = state_r;
        bit_idx_nxt = bit_idx_r;
        code_nxt    = code_r;
        flash_nxt   = flash_r;
        case (state_r)
            led_fault_pkg::PH_IDLE:
            begin
                if (legacy_r)
                begin
                    if (overtemp)
                    begin
                        state_nxt = led_fault_pkg::PH_LEGACY;
                        flash_nxt = 1'b1;
                    end
                end
                else if (|fault_vec)
                begin
                    state_nxt   = led_fault_pkg::PH_BIT_ON;
                    code_nxt    = lowest_fault(fault_vec);
                    bit_idx_nxt = `TOP_BIT;
                end
            end
            led_fault_pkg::PH_BIT_ON:
            begin
                if (done)
                    state_nxt = led_fault_pkg::PH_BIT_OFF;
            end
            led_fault_pkg::PH_BIT_OFF:
            begin
                if (done && bit_idx_r == 3'h0)
                    state_nxt = led_fault_pkg::PH_END_ON;
                else if (done)
                begin
                    state_nxt   = led_fault_pkg::PH_BIT_ON;
                    bit_idx_nxt = bit_idx_r - 3'h1;
                end
            end
            led_fault_pkg::PH_END_ON:
            begin
                if (done)
                    state_nxt = led_fault_pkg::PH_END_OFF;
            end
            led_fault_pkg::PH_END_OFF:
            begin
                if (done)
                    state_nxt = led_fault_pkg::PH_IDLE;
            end
            led_fault_pkg::PH_LEGACY:
            begin
                // leave only after a full off half
                if (done)
                begin
                    flash_nxt = !flash_r;
                    if (!flash_r && (!legacy_r || !overtemp))
                        state_nxt = led_fault_pkg::PH_IDLE;
                end
            end
            default:
            begin
                state_nxt = led_fault_pkg::PH_IDLE;
            end
        endcase
    end

    assign restart = (state_nxt != state_r)
                     || (state_r == led_fault_pkg::PH_LEGACY && done);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r   <= led_fault_pkg::PH_IDLE;
            bit_idx_r <= 3'h0;
            code_r    <= '0;
            flash_r   <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            bit_idx_r <= bit_idx_nxt;
            code_r    <= code_nxt;
            flash_r   <= flash_nxt;
        end
    end

    // phase length from the next phase and, for a bit on phase, the bit value
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_r <= 32'h0000_0000;
        else if (restart)
            cnt_r <= phase_len(state_nxt, code_nxt[bit_idx_nxt])
                     - 32'h0000_0001;
        else if (!done)
            cnt_r <= cnt_r - 32'h0000_0001;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            led_r <= 1'b0;
        else
            led_r <= (state_nxt == led_fault_pkg::PH_BIT_ON)
                     || (state_nxt == led_fault_pkg::PH_END_ON)
                     || (state_nxt == led_fault_pkg::PH_LEGACY
                         && flash_nxt);
    end

    assign led = led_r;

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            fault_any_r <= 1'b0;
        else
            fault_any_r <= |fault_vec;
    end

    always_comb
    begin
        events = '0;
        events[`EV_FRAME] = (state_r == led_fault_pkg::PH_END_OFF)
                            && done;
        events[`EV_RAISE] = (|fault_vec) && !fault_any_r;
        events[`EV_CLEAR] = !(|fault_vec) && fault_any_r;
    end

    // set beats a same-cycle write-one clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            status_r <= `STATUS_RST;
        else if (reg_req.we && reg_req.addr == `REG_STATUS)
            status_r <= (status_r & ~reg_req.wdata[`EV_W-1:0]) | events;
        else
            status_r <= status_r | events;
    end

    assign irq = |(status_r & mask_r);

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // legacy mode takes effect at the next frame boundary
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            legacy_r <= `CTRL_RST;
        else if (reg_req.we && reg_req.addr == `REG_CTRL)
            legacy_r <= reg_req.wdata[`CTRL_LEGACY];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            mask_r <= `MASK_RST;
        else if (reg_req.we && reg_req.addr == `REG_MASK)
            mask_r <= reg_req.wdata[`EV_W-1:0];
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_r <= '0;
        else if (reg_req.re)
        begin
            case (reg_req.addr)
                `REG_CTRL:   rdata_r <= {15'h0000, legacy_r};
                `REG_STATUS: rdata_r <= {13'h0000, status_r};
                `REG_MASK:   rdata_r <= {13'h0000, mask_r};
                `REG_SHOWN:  rdata_r <= {4'h0, state_r, code_r};
                `REG_ACTIVE: rdata_r <= fault_vec;
                default:     rdata_r <= '0;
            endcase
        end
        else
            rdata_r <= '0;
    end

    assign reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_zero_short_on: assert property (
        @(posedge clk) disable iff (!reset_n)
        (restart && state_nxt == led_fault_pkg::PH_BIT_ON
         && !code_nxt[bit_idx_nxt])
        |=> led_r && cnt_r == SHORT_ON_CYC - 32'h0000_0001)
        else $error("zero bit on phase has wrong length");

    a_one_medium_on: assert property (
        @(posedge clk) disable iff (!reset_n)
        (restart && state_nxt == led_fault_pkg::PH_BIT_ON
         && code_nxt[bit_idx_nxt])
        |=> led_r && cnt_r == MEDIUM_ON_CYC - 32'h0000_0001)
        else $error("one bit on phase has wrong length");

    a_bit_pause_off: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_r == led_fault_pkg::PH_BIT_ON && done)
        |=> state_r == led_fault_pkg::PH_BIT_OFF && !led_r
            && cnt_r == PAUSE_CYC - 32'h0000_0001)
        else $error("bit pause missing or wrong length");

    a_end_part_seq: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_r == led_fault_pkg::PH_END_ON && done)
        |=> state_r == led_fault_pkg::PH_END_OFF && !led_r
            && cnt_r == END_OFF_CYC - 32'h0000_0001)
        else $error("end pause not following end signal");

    a_six_bits_end: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_r == led_fault_pkg::PH_BIT_OFF && done)
        |=> (state_r == led_fault_pkg::PH_END_ON)
            == ($past(bit_idx_r) == 3'h0))
        else $error("end part not after sixth bit");

    a_code_frozen: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_r != led_fault_pkg::PH_IDLE) |=> $stable(code_r))
        else $error("code changed inside a frame");

    a_lowest_wins: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_r == led_fault_pkg::PH_IDLE
         && state_nxt == led_fault_pkg::PH_BIT_ON)
        |=> code_r == lowest_fault($past(fault_vec)))
        else $error("frame did not take lowest fault");

    a_msb_first: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_r == led_fault_pkg::PH_BIT_OFF && done
         && bit_idx_r != 3'h0)
        |=> bit_idx_r == $past(bit_idx_r) - 3'h1)
        else $error("bit order not descending");

    a_legacy_quiet: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_r == led_fault_pkg::PH_IDLE && legacy_r && !overtemp)
        |=> !led_r)
        else $error("legacy mode shows a non-temperature fault");

    c_frame_done: cover property (
        @(posedge clk) disable iff (!reset_n) events[`EV_FRAME]);

    c_one_bit: cover property (
        @(posedge clk) disable iff (!reset_n)
        state_r == led_fault_pkg::PH_BIT_ON
        && cnt_r == MEDIUM_ON_CYC - 32'h0000_0001);

    c_legacy_flash: cover property (
        @(posedge clk) disable iff (!reset_n)
        state_r == led_fault_pkg::PH_LEGACY && done && flash_r);

    c_irq_raised: cover property (
        @(posedge clk) disable iff (!reset_n) irq);

endmodule : led_fault_blink

// ---- led_fault_defs.svh ----
`ifndef LED_FAULT_DEFS_SVH
`define LED_FAULT_DEFS_SVH

// ----------------------------------------------------------------
// clock and phase times (ms)
// ----------------------------------------------------------------
// 50 MHz clock, 50000 cycles per ms
`define CLK_KHZ          32'h0000_C350
// 50 ms short on
`define SHORT_ON_MS      32'h0000_0032
// 500 ms medium on
`define MEDIUM_ON_MS     32'h0000_01F4
// 1000 ms pause after a bit
`define PAUSE_OFF_MS     32'h0000_03E8
// 2000 ms end signal and end pause
`define END_ON_MS        32'h0000_07D0
`define END_OFF_MS       32'h0000_07D0
// 10000 ms overload hold-off
`define OVERLOAD_HOLD_MS 32'h0000_2710
// 500 ms half period of the legacy flash
`define LEGACY_HALF_MS   32'h0000_01F4

// ----------------------------------------------------------------
// code layout and thresholds
// ----------------------------------------------------------------
`define CODE_W           6
`define TOP_BIT          3'h5
// 70 C set, 55 C clear
`define TEMP_SET_C       8'h46
`define TEMP_CLR_C       8'h37
`define FAULT_CONVERTER  4'h2
`define FAULT_OVERTEMP   4'h3

// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
`define REG_AW           4
`define REG_DW           16
`define REG_CTRL         4'h0
`define REG_STATUS       4'h1
`define REG_MASK         4'h2
`define REG_SHOWN        4'h3
`define REG_ACTIVE       4'h4
`define CTRL_LEGACY      0
`define EV_FRAME         0
`define EV_RAISE         1
`define EV_CLEAR         2
`define EV_W             3
`define CTRL_RST         1'h0
`define MASK_RST         3'h0
`define STATUS_RST       3'h0

`endif

// ---- led_fault_pkg.sv ----
`include "led_fault_defs.svh"

package led_fault_pkg;

    typedef struct packed {
        logic matrix_link;
        logic ext_source_link;
        logic transformer_link;
        logic ext_electronic_link;
        logic addon_module_link;
        logic user_if2_link;
        logic front_panel_link;
        logic safety_link;
        logic earth_test_link;
        logic insulation_test_link;
        logic measurement_function_link;
        logic measurement_processor_link;
        logic test_processor_link;
        logic converter_fail;
        logic overload;
    } fault_in_s;

    typedef struct packed {
        logic [`REG_AW-1:0] addr;
        logic [`REG_DW-1:0] wdata;
        logic               we;
        logic               re;
    } reg_req_s;

    typedef enum logic [5:0] {
        PH_IDLE    = 6'h01,
        PH_BIT_ON  = 6'h02,
        PH_BIT_OFF = 6'h04,
        PH_END_ON  = 6'h08,
        PH_END_OFF = 6'h10,
        PH_LEGACY  = 6'h20
    } phase_e;

endpackage : led_fault_pkg

// ---- temp_hysteresis.sv ----
`timescale 1ns/1ps
`include "led_fault_defs.svh"

module temp_hysteresis
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] temp_c,
    output logic            over_r
);

    // set above 70, clear below 55
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            over_r <= 1'b0;
        else if (temp_c > `TEMP_SET_C)
            over_r <= 1'b1;
        else if (temp_c < `TEMP_CLR_C)
            over_r <= 1'b0;
    end

    a_temp_set_high: assert property (
        @(posedge clk) disable iff (!reset_n)
        (temp_c > `TEMP_SET_C) |=> over_r)
        else $error("overtemperature not set above threshold");

    a_temp_hold_band: assert property (
        @(posedge clk) disable iff (!reset_n)
        (over_r && temp_c >= `TEMP_CLR_C) |=> over_r)
        else $error("overtemperature dropped inside band");

endmodule : temp_hysteresis

// ---- overload_hold.sv ----
`timescale 1ns/1ps
`include "led_fault_defs.svh"

module overload_hold
#(
    parameter logic [31:0] HOLD_CYC = 32'(`OVERLOAD_HOLD_MS * `CLK_KHZ)
)
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic converter_fail,
    input  wire logic overload,
    output logic      fault_r
);

    logic [31:0] hold_cnt_r;

    // overload fault drops within the hold-off
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hold_cnt_r <= 32'h0000_0000;
        else if (overload)
            hold_cnt_r <= HOLD_CYC - 32'h0000_0001;
        else if (hold_cnt_r != 32'h0000_0000)
            hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            fault_r <= 1'b0;
        else
            fault_r <= converter_fail | overload
                       | (hold_cnt_r != 32'h0000_0000);
    end

    a_overload_sets: assert property (
        @(posedge clk) disable iff (!reset_n)
        overload |=> fault_r ##1 fault_r)
        else $error("overload did not raise converter fault");

    a_overload_clears: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!overload && !converter_fail && hold_cnt_r == 32'h0000_0000)
        |=> !fault_r)
        else $error("converter fault held past hold-off");

endmodule : overload_hold

// ---- led_viewer.sv ----
`timescale 1ns/1ps

module led_viewer
#(
    parameter int SH = 3,
    parameter int MD = 8,
    parameter int PS = 5,
    parameter int EN = 12,
    parameter int EF = 12
)
(
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  led,
    input  wire logic  quiet_n,
    output logic       code_valid,
    output logic [5:0] code,
    output logic       ok
);
    logic       led_r;
    logic       ok_r;
    logic       end_r;
    logic [5:0] bits_r;
    int         run_r;
    int         cnt_r;

    // --------
    // operator eye: run lengths of each led level
    // --------
    // phase lengths, bits msb first
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n || !quiet_n)
        begin
            led_r      <= 1'b0;
            ok_r       <= 1'b1;
            end_r      <= 1'b1;
            bits_r     <= 6'h00;
            run_r      <= 0;
            cnt_r      <= 0;
            code_valid <= 1'b0;
            code       <= 6'h00;
            ok         <= 1'b0;
        end
        else
        begin
            code_valid <= 1'b0;
            led_r      <= led;
            if (led === led_r)
                run_r <= run_r + 1;
            else
            begin
                run_r <= 1;
                if (led_r && run_r == EN)
                begin
                    code_valid <= 1'b1;
                    code       <= bits_r;
                    ok         <= ok_r && cnt_r == 6;
                    ok_r       <= 1'b1;
                    cnt_r      <= 0;
                    end_r      <= 1'b1;
                end
                else if (led_r && (run_r == SH || run_r == MD))
                begin
                    bits_r <= {bits_r[4:0], run_r == MD};
                    cnt_r  <= cnt_r + 1;
                    end_r  <= 1'b0;
                end
                else if (led_r)
                    ok_r <= 1'b0;
                // idle gap after a frame may be longer than the end pause
                else if (end_r ? run_r < EF + 1 : run_r != PS)
                    ok_r <= 1'b0;
            end
        end
    end
endmodule : led_viewer

// ---- led_fault_blink_tb.sv ----
`timescale 1ns/1ps
`include "led_fault_defs.svh"

module led_fault_blink_tb;
    localparam int SH = 3, MD = 8, PS = 5, EN = 12, EF = 12, LG = 4, HD = 20;
    logic                    clk, reset_n, quiet_n, irq, led, cv, ok, re_d;
    logic [7:0]              temp_c;
    logic [14:0]             fv, v;
    logic [15:0]             rdata;
    logic [5:0]              code;
    led_fault_pkg::reg_req_s rq;
    logic [15:0]             code_q[$], rd_q[$];
    int                      bad_count, samples_checked, codes_seen, n;
    logic [3:0]  n_addr[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
    logic [15:0] n_exp[6]  = '{16'h0000, 16'h0000, 16'h0000, 16'h0040,
                               16'h0000, 16'h0000};

    led_fault_blink #(.SHORT_ON_CYC(32'(SH)), .MEDIUM_ON_CYC(32'(MD)),
        .PAUSE_CYC(32'(PS)), .END_ON_CYC(32'(EN)), .END_OFF_CYC(32'(EF)),
        .LEGACY_CYC(32'(LG)), .HOLD_CYC(32'(HD))) dut (.clk(clk),
        .reset_n(reset_n), .faults(fv), .temp_c(temp_c), .reg_req(rq),
        .reg_rdata(rdata), .led(led), .irq(irq));
    led_viewer #(.SH(SH), .MD(MD), .PS(PS), .EN(EN), .EF(EF)) viewer
        (.clk(clk), .reset_n(reset_n), .led(led), .quiet_n(quiet_n),
        .code_valid(cv), .code(code), .ok(ok));

    always #10 clk = ~clk;

    // --------
    // helpers
    // --------
    task automatic check(input string nm, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic give_verdict;
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        rq.addr  <= a;
        rq.wdata <= d;
        rq.we    <= 1'b1;
        @(posedge clk);
        rq.we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        rq.addr <= a;
        rq.re   <= 1'b1;
        @(posedge clk);
        rq.re <= 1'b0;
    endtask : rd

    task automatic wait_codes(input int k);
        int t;
        t = codes_seen + k;
        for (int i = 0; i < 400 * k && codes_seen < t; i++) @(posedge clk);
        check("frames", 16'(codes_seen), 16'(t));
    endtask : wait_codes

    // expected frame word: ok flag at bit 6, lowest fault number below
    function automatic logic [15:0] low_num(input logic [14:0] f);
        int m, b;
        b = 99;
        for (int k = 0; k < 15; k++)
            if (f[k])
            begin
                m = k < 2 ? 2 : (k == 2 ? 1 : k + 1);
                if (m < b) b = m;
            end
        return 16'h0040 | 16'(b);
    endfunction : low_num

    // --------
    // output watchers
    // --------
    always @(posedge clk) re_d <= rq.re;
    always @(negedge clk)
    begin
        if (re_d === 1'b1)
            check("rdata", rdata, rd_q.pop_front());
        if (cv === 1'b1)
        begin
            codes_seen++;
            check("code", {9'h000, ok, code},
                code_q.size() ? code_q.pop_front() : 16'hFFFF);
        end
    end

    initial
    begin
        #1_200_000;
        bad_count++;
        give_verdict();
    end

    initial
    begin
        clk = 0; reset_n = 0; quiet_n = 1; temp_c = 8'h14; fv = '0; rq = '0;
        bad_count = 0; samples_checked = 0; codes_seen = 0;
        void'($urandom(29515));
        cyc(16);
        reset_n <= 1'b1;
        foreach (n_addr[i]) rd(n_addr[i], n_exp[i]);
        fv <= 15'h0004;
        code_q.push_back(16'h0041);
        wait_codes(1);
        fv <= '0;
        cyc(EF + 6);
        rd(`REG_STATUS, 16'h0007);
        wr(`REG_MASK, 16'h0002);
        @(negedge clk) check("irq", 16'(irq), 16'h0001);
        wr(`REG_STATUS, 16'h0002);
        @(negedge clk) check("irq", 16'(irq), 16'h0000);
        rd(`REG_STATUS, 16'h0005);
        wr(`REG_MASK, 16'h0007);
        @(negedge clk) check("irq", 16'(irq), 16'h0001);
        wr(`REG_STATUS, 16'h0007);
        wr(4'hF, 16'hFFFF);
        rd(`REG_STATUS, 16'h0000);
        rd(`REG_MASK, 16'h0007);
        rd(4'hF, 16'h0000);
        wr(`REG_CTRL, 16'h0001);
        quiet_n <= 1'b0;
        fv      <= 15'h0004;
        temp_c  <= 8'h50;
        for (n = 0; n < 300 && led !== 1'b1; n++) @(negedge clk);
        n = 0;
        while (led === 1'b1 && n < 50)
        begin
            n++;
            @(negedge clk);
        end
        check("flash", 16'(n), 16'(LG));
        @(posedge clk) temp_c <= 8'h30;
        cyc(3 * LG + 4);
        n = 0;
        repeat (60) @(negedge clk) n += int'(led);
        check("legacy_quiet", 16'(n), 16'h0000);
        wr(`REG_CTRL, 16'h0000);
        fv <= '0;
        cyc(4);
        quiet_n <= 1'b1;
        cyc(EF + 4);
        // each fault input except overload alone, then random mixes
        for (int k = 1; k < 21; k++)
        begin
            v = k < 15 ? 15'(1) << k : 15'($urandom) & 15'h7FFE;
            if (v == 0) v = 15'h0004;
            // converter flag is registered: lead it by one cycle
            fv <= v & 15'h0002;
            cyc(1);
            fv <= v;
            code_q.push_back(low_num(v));
            wait_codes(1);
            fv <= '0;
            cyc(EF + 4);
        end
        // change mid-frame waits for the boundary
        fv <= 15'h0004;
        code_q.push_back(16'h0041);
        code_q.push_back(16'h004F);
        cyc(25);
        fv <= 15'h4000;
        wait_codes(2);
        fv <= '0;
        cyc(EF + 4);
        temp_c <= 8'h46;
        cyc(3);
        rd(`REG_ACTIVE, 16'h0000);
        temp_c <= 8'h47;
        code_q.push_back(16'h0043);
        cyc(3);
        rd(`REG_ACTIVE, 16'h0008);
        temp_c <= 8'h3C;
        cyc(3);
        rd(`REG_ACTIVE, 16'h0008);
        wait_codes(1);
        temp_c <= 8'h36;
        cyc(3);
        rd(`REG_ACTIVE, 16'h0000);
        cyc(EF + 4);
        fv <= 15'h0001;
        code_q.push_back(16'h0042);
        cyc(1);
        fv <= '0;
        cyc(HD - 6);
        rd(`REG_ACTIVE, 16'h0004);
        cyc(8);
        rd(`REG_ACTIVE, 16'h0000);
        wait_codes(1);
        cyc(EF + 4);
        give_verdict();
    end

endmodule : led_fault_blink_tb
